// *** timer_pkg.sv ***
// Shared constants, field layouts and carrier types of the dual 8-bit timer block
package timer_pkg;

    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;

    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_T0_CTRL = 10'h020;
    localparam logic [9:0] IDX_T1_CTRL = 10'h021;
    localparam logic [9:0] IDX_T0_PERIOD = 10'h022;
    localparam logic [9:0] IDX_T0_PULSE = 10'h023;
    localparam logic [9:0] IDX_T1_PERIOD = 10'h024;
    localparam logic [9:0] IDX_T1_PULSE = 10'h025;
    localparam logic [9:0] IDX_SYS_CFG = 10'h026;
    localparam logic [9:0] IDX_IRQ_STATUS = 10'h027;
    localparam logic [9:0] IDX_IRQ_MASK = 10'h028;
    localparam logic [9:0] IDX_COUNT = 10'h029;

    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CMP_RESET = 8'h00;
    localparam logic [1:0] SYS_CFG_RESET = 2'h0;
    localparam logic [1:0] IRQ_RESET = 2'h0;

    // System configuration bit positions
    localparam int unsigned CFG_DIV_CLK_BIT = 0;
    localparam int unsigned CFG_SLOW_BIT = 1;

    // Control register layout: bit 7 flip-flop, 6..4 clock, 3 run, 2..0 mode
    typedef struct packed {
        logic flipflop_init;
        logic [2:0] clock_select;
        logic run;
        logic [2:0] mode_select;
    } ctrl_t;

    // Clock select codes
    localparam logic [2:0] CK_DIV11 = 3'h0;
    localparam logic [2:0] CK_DIV7 = 3'h1;
    localparam logic [2:0] CK_DIV5 = 3'h2;
    localparam logic [2:0] CK_DIV3 = 3'h3;
    localparam logic [2:0] CK_LOW = 3'h4;
    localparam logic [2:0] CK_DIV1 = 3'h5;
    localparam logic [2:0] CK_FULL = 3'h6;
    localparam logic [2:0] CK_EXT = 3'h7;

    // Mode codes
    localparam logic [2:0] MODE_TIMER8 = 3'h0;
    localparam logic [2:0] MODE_DIVIDER8 = 3'h1;
    localparam logic [2:0] MODE_PWM8 = 3'h2;
    localparam logic [2:0] MODE_CASCADE = 3'h3;
    localparam logic [2:0] MODE_TIMER16 = 3'h4;
    localparam logic [2:0] MODE_WARMUP = 3'h5;
    localparam logic [2:0] MODE_PWM16 = 3'h6;
    localparam logic [2:0] MODE_PPG16 = 3'h7;

    localparam int unsigned PRESCALE_W = 11;
    localparam int unsigned LOW_DIV_W = 3;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // What one counter unit shows to the control logic
    typedef struct packed {
        logic [7:0] count;
        logic match;
        logic carry;
        logic flipflop;
    } unit_stat_t;

endpackage

// *** timer_unit.sv ***
// One 8-bit up-counter with compare and output flip-flop
`timescale 1ns/1ps
module timer_unit (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic tick_in,
    input wire logic run_in,
    input wire logic flipflop_init_in,
    input wire logic toggle_mode_in,
    input wire logic wrap_in,
    input wire logic clear_in,
    input wire logic [7:0] period_in,
    output timer_pkg::unit_stat_t stat_out
);
    import timer_pkg::*;

    logic [7:0] count_q;
    logic [7:0] count_d;
    logic run_q;
    logic ff_q;
    logic ff_d;
    wire logic hit = run_in && tick_in && !wrap_in && (count_q == period_in);
    wire logic start = run_in && !run_q;

    always_comb begin
        count_d = count_q;
        if (!run_in) begin
            count_d = 8'h00;
        end else if (clear_in) begin
            count_d = 8'h00;
        end else if (hit) begin
            count_d = 8'h00;
        end else if (tick_in) begin
            count_d = count_q + 8'h01;
        end
    end

    always_comb begin
        ff_d = ff_q;
        if (start) begin
            ff_d = flipflop_init_in;
        end else if (toggle_mode_in && (hit || clear_in)) begin
            ff_d = ~ff_q;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            count_q <= 8'h00;
            run_q <= 1'b0;
            ff_q <= 1'b0;
        end else begin
            count_q <= count_d;
            run_q <= run_in;
            ff_q <= ff_d;
        end
    end

    assign stat_out.count = count_q;
    assign stat_out.match = hit;
    assign stat_out.carry = run_in && tick_in && (count_q == 8'hff);
    assign stat_out.flipflop = ff_q;
endmodule

// *** dual_timer_control.sv ***
// Dual cascadable 8-bit timer control with AXI4-Lite register slave
`timescale 1ns/1ps
module dual_timer_control (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic [timer_pkg::ADDR_W-1:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [timer_pkg::DATA_W-1:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [timer_pkg::ADDR_W-1:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [timer_pkg::DATA_W-1:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic low_freq_tick_in,
    input wire logic timer0_external_input_in,
    input wire logic timer1_external_input_in,
    output logic [1:0] programmable_divider_output_out,
    output logic irq_out
);
    import timer_pkg::*;

    typedef enum logic [1:0] {
        WR_COLLECT = 2'b01,
        WR_RESP = 2'b10
    } wr_state_t;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_RESP = 2'b10
    } rd_state_t;

    // Register file
    ctrl_t timer0_control_q;
    ctrl_t timer1_control_q;
    logic [7:0] timer0_period_match_q;
    logic [7:0] timer0_pulse_width_q;
    logic [7:0] timer1_period_match_q;
    logic [7:0] timer1_pulse_width_q;
    logic [1:0] sys_cfg_q;
    logic [1:0] irq_status_q;
    logic [1:0] irq_status_d;
    logic [1:0] irq_mask_q;

    // Bus state
    wr_state_t wr_state_q;
    rd_state_t rd_state_q;
    logic aw_have_q;
    logic w_have_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [7:0] w_byte_q;
    logic w_lane0_q;
    logic [1:0] bresp_q;
    logic [DATA_W-1:0] rdata_q;
    logic [1:0] rresp_q;

    // Timebase
    logic [PRESCALE_W-1:0] prescale_q;
    logic [LOW_DIV_W-1:0] low_div_q;
    logic ext0_prev_q;
    logic ext1_prev_q;

    unit_stat_t stat0;
    unit_stat_t stat1;

    function automatic logic [9:0] reg_index(input logic [ADDR_W-1:0] addr);
        reg_index = addr[ADDR_W-1:2];
    endfunction

    function automatic logic known_index(input logic [9:0] idx);
        known_index = (idx >= IDX_T0_CTRL) && (idx <= IDX_COUNT);
    endfunction

    // Source tick for one timer from its clock select code
    function automatic logic pick_tick(
        input logic [2:0] sel,
        input logic div_clk_bit,
        input logic slow,
        input logic [PRESCALE_W-1:0] pre,
        input logic low_tick,
        input logic low_div8_tick,
        input logic ext_tick
    );
        logic full_rate;
        full_rate = !slow;
        case (sel)
            CK_DIV11: pick_tick = (div_clk_bit || slow) ? low_div8_tick : (&pre[10:0]);
            CK_DIV7: pick_tick = full_rate && (&pre[6:0]);
            CK_DIV5: pick_tick = full_rate && (&pre[4:0]);
            CK_DIV3: pick_tick = full_rate && (&pre[2:0]);
            CK_LOW: pick_tick = low_tick;
            CK_DIV1: pick_tick = full_rate && pre[0];
            // Passed in slow states too, for any mode that selects it
            CK_FULL: pick_tick = 1'b1;
            CK_EXT: pick_tick = ext_tick;
            default: pick_tick = 1'b0;
        endcase
    endfunction

    // Address decode and handshakes
    wire logic wr_collect = (wr_state_q == WR_COLLECT);
    wire logic rd_idle = (rd_state_q == RD_IDLE);
    wire logic do_write = wr_collect && aw_have_q && w_have_q;
    wire logic [9:0] wr_idx = reg_index(aw_addr_q);
    wire logic wr_ok = known_index(wr_idx) && (wr_idx != IDX_COUNT) && (wr_idx != IDX_IRQ_STATUS);
    wire logic wr_en = do_write && wr_ok && w_lane0_q;
    wire logic ar_take = rd_idle && s_axi_arvalid_in;
    wire logic [9:0] rd_idx = reg_index(s_axi_araddr_in);
    wire logic rd_ok = known_index(rd_idx);
    wire logic status_read = ar_take && (rd_idx == IDX_IRQ_STATUS);

    assign s_axi_awready_out = wr_collect && !aw_have_q;
    assign s_axi_wready_out = wr_collect && !w_have_q;
    assign s_axi_bvalid_out = (wr_state_q == WR_RESP);
    assign s_axi_bresp_out = bresp_q;
    assign s_axi_arready_out = rd_idle;
    assign s_axi_rvalid_out = (rd_state_q == RD_RESP);
    assign s_axi_rdata_out = rdata_q;
    assign s_axi_rresp_out = rresp_q;

    // Mode decode; cascade needs timer0 parked at 011 and timer1 in a 16-bit code
    wire logic t0_mode_cascade = (timer0_control_q.mode_select == MODE_CASCADE);
    wire logic t1_mode_wide = timer1_control_q.mode_select[2];
    wire logic cascade = t0_mode_cascade && t1_mode_wide;
    wire logic t1_reserved = (timer1_control_q.mode_select == MODE_CASCADE);
    wire logic t0_toggle = cascade ? (timer1_control_q.mode_select != MODE_TIMER16)
                                   : (timer0_control_q.mode_select == MODE_DIVIDER8);
    wire logic t1_toggle = !cascade && (timer1_control_q.mode_select == MODE_DIVIDER8);

    // Timebase ticks
    wire logic low_div8_tick = low_freq_tick_in && (&low_div_q);
    wire logic ext0_tick = timer0_external_input_in && !ext0_prev_q;
    wire logic ext1_tick = timer1_external_input_in && !ext1_prev_q;
    wire logic div_clk_bit = sys_cfg_q[CFG_DIV_CLK_BIT];
    wire logic slow_state = sys_cfg_q[CFG_SLOW_BIT];

    wire logic t0_src_tick = pick_tick(timer0_control_q.clock_select, div_clk_bit, slow_state,
                                       prescale_q, low_freq_tick_in, low_div8_tick, ext0_tick);
    wire logic t1_src_tick = pick_tick(timer1_control_q.clock_select, div_clk_bit, slow_state,
                                       prescale_q, low_freq_tick_in, low_div8_tick, ext1_tick);

    // In cascade the lower half takes its clock from timer0, start and flip-flop from timer1
    wire logic t0_run = cascade ? timer1_control_q.run : timer0_control_q.run;
    wire logic t0_ff_init = cascade ? timer1_control_q.flipflop_init
                                    : timer0_control_q.flipflop_init;
    wire logic t1_run = timer1_control_q.run && !t1_reserved;
    wire logic t1_tick = cascade ? stat0.carry : t1_src_tick;

    // Both halves are compared together so a 16-bit period clears both at once
    wire logic wide_match = cascade && t0_run && t0_src_tick
        && ({stat1.count, stat0.count} == {timer1_period_match_q, timer0_period_match_q});

    timer_unit unit0 (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .tick_in(t0_src_tick),
        .run_in(t0_run),
        .flipflop_init_in(t0_ff_init),
        .toggle_mode_in(t0_toggle),
        .wrap_in(cascade),
        .clear_in(wide_match),
        .period_in(timer0_period_match_q),
        .stat_out(stat0)
    );

    timer_unit unit1 (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .tick_in(t1_tick),
        .run_in(t1_run),
        .flipflop_init_in(timer1_control_q.flipflop_init),
        .toggle_mode_in(t1_toggle),
        .wrap_in(cascade),
        .clear_in(wide_match),
        .period_in(timer1_period_match_q),
        .stat_out(stat1)
    );

    // Match events; a status read in the same cycle as a new event keeps the event
    wire logic [1:0] match_events = {cascade ? wide_match : stat1.match, stat0.match};
    always_comb begin
        irq_status_d = irq_status_q;
        if (status_read) begin
            irq_status_d = 2'b00;
        end
        irq_status_d = irq_status_d | match_events;
    end

    wire logic [31:0] rd_value =
        (rd_idx == IDX_T0_CTRL) ? {24'h000000, timer0_control_q} :
        (rd_idx == IDX_T1_CTRL) ? {24'h000000, timer1_control_q} :
        (rd_idx == IDX_T0_PERIOD) ? {24'h000000, timer0_period_match_q} :
        (rd_idx == IDX_T0_PULSE) ? {24'h000000, timer0_pulse_width_q} :
        (rd_idx == IDX_T1_PERIOD) ? {24'h000000, timer1_period_match_q} :
        (rd_idx == IDX_T1_PULSE) ? {24'h000000, timer1_pulse_width_q} :
        (rd_idx == IDX_SYS_CFG) ? {30'h00000000, sys_cfg_q} :
        (rd_idx == IDX_IRQ_STATUS) ? {30'h00000000, irq_status_q} :
        (rd_idx == IDX_IRQ_MASK) ? {30'h00000000, irq_mask_q} :
        (rd_idx == IDX_COUNT) ? {16'h0000, stat1.count, stat0.count} :
        32'h00000000;

    // Write channel
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            wr_state_q <= WR_COLLECT;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= '0;
            w_byte_q <= 8'h00;
            w_lane0_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else begin
            case (wr_state_q)
                WR_COLLECT: begin
                    if (s_axi_awvalid_in && !aw_have_q) begin
                        aw_have_q <= 1'b1;
                        aw_addr_q <= s_axi_awaddr_in;
                    end
                    if (s_axi_wvalid_in && !w_have_q) begin
                        w_have_q <= 1'b1;
                        w_byte_q <= s_axi_wdata_in[7:0];
                        w_lane0_q <= s_axi_wstrb_in[0];
                    end
                    if (do_write) begin
                        wr_state_q <= WR_RESP;
                        bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
                    end
                end
                WR_RESP: begin
                    if (s_axi_bready_in) begin
                        wr_state_q <= WR_COLLECT;
                        aw_have_q <= 1'b0;
                        w_have_q <= 1'b0;
                    end
                end
                default: wr_state_q <= WR_COLLECT;
            endcase
        end
    end

    // Read channel
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            rd_state_q <= RD_IDLE;
            rdata_q <= 32'h00000000;
            rresp_q <= RESP_OKAY;
        end else begin
            case (rd_state_q)
                RD_IDLE: begin
                    if (ar_take) begin
                        rd_state_q <= RD_RESP;
                        rdata_q <= rd_value;
                        rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
                    end
                end
                RD_RESP: begin
                    if (s_axi_rready_in) begin
                        rd_state_q <= RD_IDLE;
                    end
                end
                default: rd_state_q <= RD_IDLE;
            endcase
        end
    end

    // Register file; fields are stored as written, guarding them while counting is software's job
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            timer0_control_q <= CTRL_RESET;
            timer1_control_q <= CTRL_RESET;
            timer0_period_match_q <= CMP_RESET;
            timer0_pulse_width_q <= CMP_RESET;
            timer1_period_match_q <= CMP_RESET;
            timer1_pulse_width_q <= CMP_RESET;
            sys_cfg_q <= SYS_CFG_RESET;
            irq_mask_q <= IRQ_RESET;
        end else if (wr_en) begin
            case (wr_idx)
                IDX_T0_CTRL: timer0_control_q <= w_byte_q;
                IDX_T1_CTRL: timer1_control_q <= w_byte_q;
                IDX_T0_PERIOD: timer0_period_match_q <= w_byte_q;
                IDX_T0_PULSE: timer0_pulse_width_q <= w_byte_q;
                IDX_T1_PERIOD: timer1_period_match_q <= w_byte_q;
                IDX_T1_PULSE: timer1_pulse_width_q <= w_byte_q;
                IDX_SYS_CFG: sys_cfg_q <= w_byte_q[1:0];
                IDX_IRQ_MASK: irq_mask_q <= w_byte_q[1:0];
                default: irq_mask_q <= irq_mask_q;
            endcase
        end
    end

    // Timebase and interrupt state
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            prescale_q <= '0;
            low_div_q <= '0;
            ext0_prev_q <= 1'b0;
            ext1_prev_q <= 1'b0;
            irq_status_q <= IRQ_RESET;
            irq_out <= 1'b0;
        end else begin
            prescale_q <= prescale_q + 11'h001;
            if (low_freq_tick_in) begin
                low_div_q <= low_div_q + 3'h1;
            end
            ext0_prev_q <= timer0_external_input_in;
            ext1_prev_q <= timer1_external_input_in;
            irq_status_q <= irq_status_d;
            irq_out <= |(irq_status_d & irq_mask_q);
        end
    end

    assign programmable_divider_output_out = {stat1.flipflop, stat0.flipflop};
endmodule

// *** dual_timer_control_props.sv ***
// Bus and register-map assertions for the dual timer block
`timescale 1ns/1ps
module dual_timer_control_props import timer_pkg::*; (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    input wire logic s_axi_awready_out,
    input wire logic s_axi_wvalid_in,
    input wire logic s_axi_wready_out,
    input wire logic [1:0] s_axi_bresp_out,
    input wire logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [ADDR_W-1:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    input wire logic s_axi_arready_out,
    input wire logic [DATA_W-1:0] s_axi_rdata_out,
    input wire logic [1:0] s_axi_rresp_out,
    input wire logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in
);
    logic [9:0] ar_idx_q;
    wire [9:0] aw_idx = s_axi_awaddr_in[11:2];
    wire [9:0] ar_idx = s_axi_araddr_in[11:2];
    wire ar_take = s_axi_arvalid_in && s_axi_arready_out;
    wire ar_mapped = ar_idx >= IDX_T0_CTRL && ar_idx <= IDX_COUNT;
    // Status and count are read-only, so writes there are refused too
    wire aw_refused = aw_idx < IDX_T0_CTRL || aw_idx > IDX_IRQ_MASK || aw_idx == IDX_IRQ_STATUS;
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) ar_idx_q <= '0;
        else if (ar_take) ar_idx_q <= ar_idx;
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    sequence s_wr_taken;
        s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
    endsequence
    sequence s_wr_answer(logic [1:0] code);
        ##[1:2] (s_axi_bvalid_out && s_axi_bresp_out == code);
    endsequence
    a_write_ok: assert property (
        s_wr_taken ##0 !aw_refused |-> s_wr_answer(RESP_OKAY)) else $error("writable register not answered OKAY");
    a_write_refused: assert property (
        s_wr_taken ##0 aw_refused |-> s_wr_answer(RESP_SLVERR)) else $error("refused write not answered SLVERR");
    a_write_hold: assert property (
        s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
        else $error("write response dropped early");
    a_read_answer: assert property (ar_take |=> s_axi_rvalid_out) else $error("read not answered next cycle");
    a_read_hold: assert property (
        s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out)
        && $stable(s_axi_rresp_out)) else $error("read response changed before taken");
    a_read_block: assert property (s_axi_rvalid_out |-> !s_axi_arready_out) else $error("read accepted while busy");
    a_read_unmapped: assert property (
        ar_take && !ar_mapped |=> s_axi_rresp_out == RESP_SLVERR && s_axi_rdata_out == '0)
        else $error("unmapped read not refused");
    a_reg_width: assert property (
        s_axi_rvalid_out && ar_idx_q >= IDX_T0_CTRL && ar_idx_q <= IDX_T1_PULSE
        |-> s_axi_rdata_out[31:8] == '0 && s_axi_rresp_out == RESP_OKAY) else $error("byte register read wrong");
endmodule
bind dual_timer_control dual_timer_control_props u_props (.clk_in, .reset_in, .s_axi_awaddr_in, .s_axi_awvalid_in,
    .s_axi_awready_out, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
    .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out,
    .s_axi_rready_in);

// *** tb.sv ***
// Self-checking bench for the dual timer control block
`timescale 1ns/1ps
module tb;
    import timer_pkg::*;
    typedef struct {logic [9:0] idx; logic [31:0] wd; logic [3:0] st; logic [1:0] wr; logic [31:0] rd; logic [1:0] rr;} row_t;
    typedef struct {logic [2:0] ck; logic [31:0] cfg; logic [7:0] exp;} rate_row_t;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic [11:0] awaddr = 12'h0;
    logic [11:0] araddr = 12'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic fs_tick = 1'b0;
    logic ext_pin = 1'b0;
    logic [3:0] fs_cnt = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp, programmable_divider_output, r;
    logic [31:0] rdata, d;
    int err_count = 0;
    int samples_checked = 0;
    row_t rows [10] = '{
        '{IDX_T0_CTRL, 32'hffff_ff77, 4'hf, RESP_OKAY, 32'h77, RESP_OKAY},
        '{IDX_T1_CTRL, 32'hf7, 4'hf, RESP_OKAY, 32'hf7, RESP_OKAY},
        '{IDX_T0_PERIOD, 32'hff, 4'hf, RESP_OKAY, 32'hff, RESP_OKAY},
        '{IDX_T0_PERIOD, 32'h11, 4'he, RESP_OKAY, 32'hff, RESP_OKAY},
        '{IDX_T0_PULSE, 32'h80, 4'hf, RESP_OKAY, 32'h80, RESP_OKAY},
        '{IDX_T1_PERIOD, 32'h1, 4'hf, RESP_OKAY, 32'h1, RESP_OKAY},
        '{IDX_T1_PULSE, 32'hfe, 4'hf, RESP_OKAY, 32'hfe, RESP_OKAY},
        '{10'h02a, 32'h55, 4'hf, RESP_SLVERR, 32'h0, RESP_SLVERR},
        '{IDX_IRQ_STATUS, 32'h3, 4'hf, RESP_SLVERR, 32'h0, RESP_OKAY},
        '{IDX_COUNT, 32'h3, 4'hf, RESP_SLVERR, 32'h0, RESP_OKAY}};
    // Expected counts in a 128-cycle window; slow state silences fc/2^3
    rate_row_t rates [7] = '{'{CK_FULL, 32'h0, 8'h80}, '{CK_DIV1, 32'h0, 8'h40}, '{CK_DIV3, 32'h0, 8'h10},
        '{CK_DIV5, 32'h0, 8'h04}, '{CK_LOW, 32'h0, 8'h08}, '{CK_EXT, 32'h0, 8'h10}, '{CK_DIV3, 32'h2, 8'h00}};
    dual_timer_control u_dual_timer_control (.clk_in(clk_in), .reset_in(reset_in),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
        .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
        .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
        .low_freq_tick_in(fs_tick), .timer0_external_input_in(ext_pin), .timer1_external_input_in(ext_pin),
        .programmable_divider_output_out(programmable_divider_output), .irq_out(irq));
    always #20 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        fs_cnt <= fs_cnt + 4'h1;
        fs_tick <= fs_cnt == 4'hf;
        if (fs_cnt[1:0] == 2'h3) begin
            ext_pin <= ~ext_pin;
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Ready is sampled at the falling edge, where it has settled
    task automatic wr(input logic [9:0] idx, input logic [31:0] v, input logic [3:0] s, output logic [1:0] resp);
        bit aw_done, w_done, aw_hs, w_hs;
        @(posedge clk_in);
        awaddr <= {idx, 2'b00};
        wdata <= v;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        aw_done = 0;
        w_done = 0;
        while (!(aw_done && w_done)) begin
            @(negedge clk_in);
            aw_hs = !aw_done && awready;
            w_hs = !w_done && wready;
            @(posedge clk_in);
            if (aw_hs) begin
                awvalid <= 1'b0;
                aw_done = 1;
            end
            if (w_hs) begin
                wvalid <= 1'b0;
                w_done = 1;
            end
        end
        do @(negedge clk_in); while (bvalid !== 1'b1);
        @(posedge clk_in);
        bready <= 1'b1;
        @(negedge clk_in);
        resp = bresp;
        @(posedge clk_in);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [9:0] idx, output logic [31:0] v, output logic [1:0] resp);
        bit hs;
        @(posedge clk_in);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        do begin
            @(negedge clk_in);
            hs = arready;
            @(posedge clk_in);
        end while (!hs);
        arvalid <= 1'b0;
        do @(negedge clk_in); while (rvalid !== 1'b1);
        @(posedge clk_in);
        rready <= 1'b1;
        @(negedge clk_in);
        v = rdata;
        resp = rresp;
        @(posedge clk_in);
        rready <= 1'b0;
    endtask
    task automatic set(input logic [9:0] idx, input logic [31:0] v);
        wr(idx, v, 4'hf, r);
    endtask
    task automatic expect_rd(input logic [9:0] idx, input logic [31:0] m, input logic [31:0] exp);
        rd(idx, d, r);
        check(d & m, exp);
    endtask
    task automatic done(input string name);
        $display("test %s finished", name);
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_in);
        err_count++;
        end_of_test();
    end
    initial begin
        repeat (12) @(posedge clk_in);
        reset_in <= 1'b0;
        for (int i = 32; i <= 41; i++) begin
            expect_rd(i[9:0], 32'hffff_ffff, 32'h0);
        end
        done("reset values");
        foreach (rows[i]) begin
            wr(rows[i].idx, rows[i].wd, rows[i].st, r);
            check({30'h0, r}, {30'h0, rows[i].wr});
            rd(rows[i].idx, d, r);
            check(d, rows[i].rd);
            check({30'h0, r}, {30'h0, rows[i].rr});
        end
        for (int m = 0; m < 8; m++) begin
            set(IDX_T1_CTRL, 32'(m));
            expect_rd(IDX_T1_CTRL, 32'hff, 32'(m));
        end
        done("register table");
        foreach (rates[i]) begin
            set(IDX_SYS_CFG, rates[i].cfg);
            set(IDX_T0_CTRL, {24'h0, 1'b0, rates[i].ck, 4'h8});
            repeat (128) @(posedge clk_in);
            rd(IDX_COUNT, d, r);
            check({31'h0, d[7:0] + 9'd4 >= rates[i].exp && d[7:0] <= rates[i].exp + 9'd4}, 32'h1);
            set(IDX_T0_CTRL, 32'h0);
        end
        set(IDX_SYS_CFG, 32'h0);
        done("clock select");
        set(IDX_T0_PERIOD, 32'h4);
        set(IDX_T0_CTRL, 32'he8);
        repeat (20) @(posedge clk_in);
        check({31'h0, irq}, 32'h0);
        check({31'h0, programmable_divider_output[0]}, 32'h1);
        expect_rd(IDX_IRQ_STATUS, 32'h1, 32'h1);
        expect_rd(IDX_COUNT, 32'hf8, 32'h0);
        set(IDX_IRQ_MASK, 32'h1);
        repeat (8) @(posedge clk_in);
        check({31'h0, irq}, 32'h1);
        set(IDX_T0_CTRL, 32'he0);
        expect_rd(IDX_T0_CTRL, 32'hff, 32'he0);
        rd(IDX_IRQ_STATUS, d, r);
        expect_rd(IDX_IRQ_STATUS, 32'hff, 32'h0);
        expect_rd(IDX_COUNT, 32'hffff_ffff, 32'h0);
        check({31'h0, irq}, 32'h0);
        set(IDX_T0_PERIOD, 32'hff);
        set(IDX_T0_CTRL, 32'h69);
        repeat (4) @(posedge clk_in);
        check({31'h0, programmable_divider_output[0]}, 32'h0);
        repeat (256) @(posedge clk_in);
        check({31'h0, programmable_divider_output[0]}, 32'h1);
        set(IDX_T0_CTRL, 32'h61);
        done("single timer");
        set(IDX_T0_PERIOD, 32'h2);
        set(IDX_T1_PERIOD, 32'h1);
        set(IDX_IRQ_MASK, 32'h2);
        set(IDX_T0_CTRL, 32'h63);
        set(IDX_T1_CTRL, 32'h8c);
        repeat (100) @(posedge clk_in);
        check({31'h0, irq}, 32'h0);
        repeat (250) @(posedge clk_in);
        check({31'h0, irq}, 32'h1);
        check({31'h0, programmable_divider_output[1]}, 32'h1);
        expect_rd(IDX_IRQ_STATUS, 32'h2, 32'h2);
        set(IDX_T1_CTRL, 32'h84);
        expect_rd(IDX_COUNT, 32'hffff_ffff, 32'h0);
        set(IDX_T0_CTRL, 32'h0);
        set(IDX_T1_CTRL, 32'h6b);
        repeat (20) @(posedge clk_in);
        expect_rd(IDX_COUNT, 32'hff00, 32'h0);
        set(IDX_T1_CTRL, 32'h0);
        done("cascade and reserved");
        end_of_test();
    end
endmodule
